// ---- verilog/spi_len_pkg.sv ----
// Shared constants and decoding for the SPI data-phase length link
package spi_len_pkg;
  // Length selector codes
  localparam logic [1:0] LEN_VAR  = 2'h0;
  localparam logic [1:0] LEN_FIX1 = 2'h1;
  localparam logic [1:0] LEN_FIX2 = 2'h2;
  localparam logic [1:0] LEN_FIX4 = 2'h3;
  // Direction bit values
  localparam logic DIR_READ  = 1'h0;
  localparam logic DIR_WRITE = 1'h1;
  // Control byte field positions
  localparam int CTRL_BSEL_POS = 3;
  localparam int CTRL_DIR_POS  = 2;
  localparam int CTRL_LEN_POS  = 0;
  // Bit indices inside the frame phases, and the header length in bytes
  localparam logic [3:0] ADDR_LAST    = 4'hF;
  localparam logic [3:0] CTRL_LAST    = 4'h7;
  localparam logic [3:0] CTRL_DIR_IDX = 4'h5;
  localparam logic [3:0] BYTE_LAST    = 4'h7;
  localparam logic [8:0] HDR_BYTES    = 9'h003;
  // Serial clock made by the host from its own clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCLK_HALF_NS  = 400;
  localparam logic [3:0] SCLK_HALF_CYC =
    4'(SCLK_HALF_NS / CLK_PERIOD_NS);

  // Data-phase byte count for a fixed code, zero for variable
  function automatic logic [2:0] fixed_len(input logic [1:0] sel);
    unique case (sel)
      LEN_FIX1: fixed_len = 3'h1;
      LEN_FIX2: fixed_len = 3'h2;
      LEN_FIX4: fixed_len = 3'h4;
      default: fixed_len = 3'h0;
    endcase
  endfunction
endpackage

// ---- verilog/spi_link_if.sv ----
// Four-wire SPI link between host and device ends
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic chip_select_n;
  modport host (
    output sclk,
    output mosi,
    output chip_select_n,
    input  miso
  );
  modport device (
    input  sclk,
    input  mosi,
    input  chip_select_n,
    output miso
  );
endinterface

// ---- verilog/spi_len_device.sv ----
// Device end: frame phases, data-phase length and user crossing
`timescale 1ns/100ps
// Behaviour
// - Mode 00 variable; 01/10/11 give 1/2/4 bytes
// - Data bytes shift most significant bit first
// - Host writes 00 to request variable length
// - Chip select falling/rising marks frame start/end
// - Variable data only while chip select low
// - Direction 1 writes; host data changes on falling
// - Direction 0 reads; device data changes on falling
// - Several variable-length bytes form sequential access
// - Fixed mode keeps chip select low permanently
// - Fixed mode host sends exactly announced byte count
module spi_len_device (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  spi_link_if.device       link,
  output logic             wr_stb,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic             rd_stb,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data
);
  typedef enum logic [2:0] {
    PH_ADDR = 3'b001,
    PH_CTRL = 3'b010,
    PH_DATA = 3'b100
  } link_phase_t;

  // System clock domain
  logic        link_rst_q;
  logic [2:0]  wr_sync_q;
  logic [2:0]  rq_sync_q;
  logic [7:0]  rdata_q;
  // Link clock domain
  link_phase_t phase_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [15:0] addr_q;
  logic [15:0] ptr_q;
  logic [15:0] rptr_q;
  logic        dir_q;
  logic [1:0]  len_q;
  logic [2:0]  left_q;
  logic [7:0]  tx_q;
  logic        miso_q;
  logic        wr_tog_q;
  logic [23:0] wr_word_q;
  logic        rq_tog_q;
  logic [15:0] rq_addr_q;

  // Frame end from chip select clears the link logic, except the toggles and their word registers, at once
  wire frame_rst = link.chip_select_n | link_rst_q;

  wire [7:0] bit_in    = {sh_q[6:0], link.mosi};
  wire       in_addr   = (phase_q == PH_ADDR);
  wire       in_ctrl   = (phase_q == PH_CTRL);
  wire       in_data   = (phase_q == PH_DATA);
  wire       addr_last = in_addr && (cnt_q == spi_len_pkg::ADDR_LAST);
  wire       ctrl_last = in_ctrl && (cnt_q == spi_len_pkg::CTRL_LAST);
  wire       dir_slot  = in_ctrl && (cnt_q == spi_len_pkg::CTRL_DIR_IDX);
  wire       byte_last = in_data && (cnt_q == spi_len_pkg::BYTE_LAST);
  wire [1:0] len_in    = {sh_q[0], link.mosi};
  wire       var_mode  = (len_q == spi_len_pkg::LEN_VAR);
  // Another byte follows the current one in this frame
  wire       more      = var_mode || (left_q > 3'h1);
  wire       fix_done  = byte_last && !var_mode && (left_q == 3'h1);
  wire       is_read   = (dir_q == spi_len_pkg::DIR_READ);
  // Reads fetch one byte ahead, so a variable frame fetches a spare
  wire       rd_first  = dir_slot && (link.mosi == spi_len_pkg::DIR_READ);
  wire       rd_next   = in_data && (cnt_q == 4'h0) && is_read && more;
  wire       rq_fire   = rd_first || rd_next;
  wire [15:0] rq_src   = rd_first ? addr_q : rptr_q;
  wire       wr_fire   = byte_last && !is_read;
  wire       tx_load   = ctrl_last || (byte_last && more);
  wire [3:0] cnt_d     = (addr_last || ctrl_last || byte_last) ?
                         4'h0 : cnt_q + 4'h1;

  // Frame phase sequencing on the link clock
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      phase_q <= PH_ADDR;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      addr_q  <= 16'h0000;
      dir_q   <= spi_len_pkg::DIR_READ;
      len_q   <= spi_len_pkg::LEN_VAR;
      left_q  <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      sh_q  <= bit_in;
      if (in_addr) begin
        addr_q <= {addr_q[14:0], link.mosi};
      end
      if (dir_slot) begin
        dir_q <= link.mosi;
      end
      if (addr_last) begin
        phase_q <= PH_CTRL;
      end
      if (ctrl_last) begin
        phase_q <= PH_DATA;
        len_q   <= len_in;
        left_q  <= spi_len_pkg::fixed_len(len_in);
      end
      if (byte_last && !var_mode) begin
        left_q <= left_q - 3'h1;
      end
      if (fix_done) begin
        phase_q <= PH_ADDR;
      end
    end
  end

  // Address pointers step once per byte for sequential access
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      ptr_q  <= 16'h0000;
      rptr_q <= 16'h0000;
    end else begin
      if (addr_last) begin
        ptr_q <= {addr_q[14:0], link.mosi};
      end else if (wr_fire) begin
        ptr_q <= ptr_q + 16'h0001;
      end
      if (rq_fire) begin
        rptr_q <= rq_src + 16'h0001;
      end
    end
  end

  // Read shifter, loaded from the prefetched byte
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx_q <= 8'h00;
    end else if (tx_load) begin
      tx_q <= rdata_q;
    end else if (in_data) begin
      tx_q <= {tx_q[6:0], 1'h0};
    end
  end

  // Read data changes on the falling serial clock edge
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      miso_q <= 1'h0;
    end else begin
      miso_q <= tx_q[7];
    end
  end

  assign link.miso = miso_q;

  // Toggles survive frame ends so the far side never sees a false edge
  always_ff @(posedge link.sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      wr_tog_q  <= 1'h0;
      wr_word_q <= 24'h000000;
      rq_tog_q  <= 1'h0;
      rq_addr_q <= 16'h0000;
    end else if (!link.chip_select_n) begin
      if (wr_fire) begin
        wr_tog_q  <= ~wr_tog_q;
        wr_word_q <= {ptr_q, bit_in};
      end
      if (rq_fire) begin
        rq_tog_q  <= ~rq_tog_q;
        rq_addr_q <= rq_src;
      end
    end
  end

  wire wr_edge = wr_sync_q[2] ^ wr_sync_q[1];
  wire rq_edge = rq_sync_q[2] ^ rq_sync_q[1];

  // System side; word registers are stable while their toggle travels
  always_ff @(posedge clk) begin
    if (rst) begin
      link_rst_q <= 1'h1;
      wr_sync_q  <= 3'h0;
      rq_sync_q  <= 3'h0;
      rdata_q    <= 8'h00;
      wr_stb     <= 1'h0;
      wr_addr    <= 16'h0000;
      wr_data    <= 8'h00;
      rd_stb     <= 1'h0;
      rd_addr    <= 16'h0000;
    end else if (ce) begin
      link_rst_q <= 1'h0;
      wr_sync_q  <= {wr_sync_q[1:0], wr_tog_q};
      rq_sync_q  <= {rq_sync_q[1:0], rq_tog_q};
      wr_stb     <= wr_edge;
      rd_stb     <= rq_edge;
      if (wr_edge) begin
        wr_addr <= wr_word_q[23:8];
        wr_data <= wr_word_q[7:0];
      end
      if (rq_edge) begin
        rd_addr <= rq_addr_q;
      end
      // Lands within half a serial bit, well before the shifter loads it
      if (rd_stb) begin
        rdata_q <= rd_data;
      end
    end
  end
endmodule

// ---- verilog/spi_len_host.sv ----
// Host end: builds frames and drives the serial clock by a divider
`timescale 1ns/100ps
module spi_len_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  spi_link_if.host         link,
  input  wire logic        go,
  input  wire logic [15:0] addr,
  input  wire logic [4:0]  block_sel,
  input  wire logic        access_direction_bit,
  input  wire logic [1:0]  op_length_select,
  input  wire logic [7:0]  var_len,
  input  wire logic [7:0]  tx_data,
  output logic             busy,
  output logic             tx_next,
  output logic             rx_valid,
  output logic [7:0]       rx_data
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW  = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_END  = 4'b1000
  } host_state_t;

  host_state_t st_q;
  logic [3:0]  div_q;
  logic [2:0]  bit_q;
  logic [8:0]  bi_q;
  logic [8:0]  last_q;
  logic [23:0] hdr_q;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;
  logic        dir_q;
  logic        var_q;
  logic [1:0]  miso_s_q;
  logic        sclk_q;
  logic        mosi_q;
  logic        cs_n_q;

  wire [7:0] ctrl_byte = {block_sel, access_direction_bit,
                          op_length_select};
  wire       go_var    = (op_length_select == spi_len_pkg::LEN_VAR);
  // Fixed frames carry exactly the announced count
  wire [7:0] len       = go_var ? var_len :
                         {5'h00, spi_len_pkg::fixed_len(op_length_select)};
  wire       half_end  = (div_q == spi_len_pkg::SCLK_HALF_CYC - 4'h1);
  wire [8:0] nbi       = bi_q + 9'h001;
  wire       nxt_data  = (nbi >= spi_len_pkg::HDR_BYTES);
  wire [7:0] hdr_byte  = (nbi == 9'h001) ? hdr_q[15:8] : hdr_q[7:0];
  wire       is_write  = (dir_q == spi_len_pkg::DIR_WRITE);
  wire [7:0] nxt_byte  = !nxt_data ? hdr_byte :
                         (is_write ? tx_data : 8'h00);
  wire [7:0] rx_d      = {rx_q[6:0], miso_s_q[1]};
  wire       byte_end  = (bit_q == 3'h7);
  wire       rd_byte   = !is_write && (bi_q >= spi_len_pkg::HDR_BYTES);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= ST_IDLE;
      div_q    <= 4'h0;
      bit_q    <= 3'h0;
      bi_q     <= 9'h000;
      last_q   <= 9'h000;
      hdr_q    <= 24'h000000;
      tx_q     <= 8'h00;
      rx_q     <= 8'h00;
      dir_q    <= spi_len_pkg::DIR_READ;
      var_q    <= 1'h1;
      miso_s_q <= 2'h0;
      sclk_q   <= 1'h0;
      mosi_q   <= 1'h0;
      cs_n_q   <= 1'h1;
      busy     <= 1'h0;
      tx_next  <= 1'h0;
      rx_valid <= 1'h0;
      rx_data  <= 8'h00;
    end else if (ce) begin
      miso_s_q <= {miso_s_q[0], link.miso};
      tx_next  <= 1'h0;
      rx_valid <= 1'h0;
      div_q    <= half_end ? 4'h0 : div_q + 4'h1;
      unique case (st_q)
        ST_IDLE: begin
          div_q <= 4'h0;
          if (go) begin
            st_q   <= ST_LOW;
            busy   <= 1'h1;
            cs_n_q <= 1'h0;
            hdr_q  <= {addr, ctrl_byte};
            tx_q   <= addr[15:8];
            mosi_q <= addr[15];
            bit_q  <= 3'h0;
            bi_q   <= 9'h000;
            last_q <= 9'(len) + spi_len_pkg::HDR_BYTES - 9'h001;
            dir_q  <= access_direction_bit;
            var_q  <= go_var;
          end
        end
        ST_LOW: begin
          if (half_end) begin
            st_q   <= ST_HIGH;
            sclk_q <= 1'h1;
          end
        end
        ST_HIGH: begin
          if (half_end) begin
            // Miso sampled late in the high half, after its sync delay
            rx_q   <= rx_d;
            sclk_q <= 1'h0;
            st_q   <= ST_LOW;
            bit_q  <= bit_q + 3'h1;
            if (!byte_end) begin
              tx_q   <= {tx_q[6:0], 1'h0};
              mosi_q <= tx_q[6];
            end else begin
              if (rd_byte) begin
                rx_valid <= 1'h1;
                rx_data  <= rx_d;
              end
              if (bi_q == last_q) begin
                st_q <= ST_END;
              end else begin
                bi_q    <= nbi;
                tx_q    <= nxt_byte;
                mosi_q  <= nxt_byte[7];
                tx_next <= nxt_data && is_write;
              end
            end
          end
        end
        ST_END: begin
          if (half_end) begin
            st_q   <= ST_IDLE;
            busy   <= 1'h0;
            // Fixed frames leave chip select low for good
            cs_n_q <= var_q;
          end
        end
      endcase
    end
  end

  assign link.sclk          = sclk_q;
  assign link.mosi          = mosi_q;
  assign link.chip_select_n = cs_n_q;
endmodule

// ---- test/spi_frame_data_phase_length_monitor.sv ----
// Checker for the serial link between host and device ends
`timescale 1ns/100ps
module spi_frame_data_phase_length_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic chip_select_n
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [1:0] len_q;
  logic [1:0] len_d;
  logic       sclk_q;
  logic       bit_q;
  logic       rise;
  logic [7:0] fix_end;
  logic       fend;

  // Fixed frames never raise select, so frames are cut by bit count
  assign rise = sclk && !sclk_q;
  assign fix_end = (len_q == 2'h3) ? 8'h38 : 8'h18 + {3'h0, len_q, 3'h0};
  assign fend = (len_q != 2'h0) && (cnt_q == fix_end);
  assign cnt_d = (chip_select_n || fend) ? 8'h00 : cnt_q + {7'h0, rise};
  assign len_d = (rise && cnt_q == 8'h17) ? {bit_q, mosi} : len_q;

  always_ff @(posedge clk) begin
    cnt_q <= rst ? 8'h00 : cnt_d;
    len_q <= rst ? 2'h0 : len_d;
    sclk_q <= rst ? 1'b0 : sclk;
    bit_q <= rise ? mosi : bit_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_high4; sclk [*4] ##1 !sclk; endsequence
  sequence s_low4; !sclk [*4]; endsequence

  property p_idle_sclk; chip_select_n |-> !sclk; endproperty
  property p_mosi_hold; sclk && sclk_q |-> $stable(mosi); endproperty
  property p_miso_hold;
    !chip_select_n && sclk && sclk_q |-> $stable(miso);
  endproperty
  property p_high_half; $rose(sclk) |-> s_high4; endproperty
  property p_low_half; $fell(sclk) |-> s_low4; endproperty
  property p_var_end;
    $rose(chip_select_n) |-> cnt_q[2:0] == 3'h0 && cnt_q >= 8'h20;
  endproperty
  property p_var_code; $rose(chip_select_n) |-> len_q == 2'h0; endproperty
  property p_fix_sel; fend |-> !chip_select_n [*8]; endproperty

  a_idle_sclk: assert property (p_idle_sclk)
    else $error("serial clock active while deselected");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while clock high");
  a_miso_hold: assert property (p_miso_hold)
    else $error("device data moved while clock high");
  a_high_half: assert property (p_high_half)
    else $error("clock high half not four cycles");
  a_low_half: assert property (p_low_half)
    else $error("clock low half under four cycles");
  a_var_end: assert property (p_var_end)
    else $error("frame ended off a byte boundary");
  a_var_code: assert property (p_var_code)
    else $error("select raised after a fixed length code");
  a_fix_sel: assert property (p_fix_sel)
    else $error("select raised in fixed length mode");
endmodule

// ---- test/spi_frame_data_phase_length_tb.sv ----
// Self-checking bench: host end talks to device end over one link
`timescale 1ns/100ps
module spi_frame_data_phase_length_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [4:0]  block_sel = 5'h00;
  logic        dir = 1'b0;
  logic [1:0]  len_sel = 2'h0;
  logic [7:0]  var_len = 8'h01;
  logic [7:0]  tx_data = 8'h00;
  logic [7:0]  key = 8'h00;
  logic        busy;
  logic        tx_next;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        wr_stb;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        rd_stb;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data;
  logic [31:0] seed = 32'h00000044;
  logic [7:0]  wd [0:7];
  int          errors = 0;
  int          checks_done = 0;

  spi_link_if link ();
  always #50 clk = ~clk;
  // Bench memory: byte depends on address and a per-frame key
  assign rd_data = rd_addr[7:0] ^ key;

  spi_len_host spi_len_host_i (
    .clk(clk), .rst(rst), .ce(1'b1), .link(link.host), .go(go),
    .addr(addr), .block_sel(block_sel), .access_direction_bit(dir),
    .op_length_select(len_sel), .var_len(var_len), .tx_data(tx_data),
    .busy(busy), .tx_next(tx_next), .rx_valid(rx_valid),
    .rx_data(rx_data));
  spi_len_device spi_len_device_i (
    .clk(clk), .rst(rst), .ce(1'b1), .link(link.device),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data));
  spi_frame_data_phase_length_monitor mon_i (
    .clk(clk), .rst(rst), .sclk(link.sclk), .mosi(link.mosi),
    .miso(link.miso), .chip_select_n(link.chip_select_n));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] flen(input logic [1:0] m,
                                      input logic [3:0] n);
    return (m == 2'h0) ? n : (m == 2'h3) ? 4'h4 : {2'h0, m};
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One frame; called just after a rising edge
  task automatic frame(input logic d, input logic [1:0] m,
                       input logic [3:0] n);
    logic [3:0] nb = flen(m, n);
    logic [3:0] wi = 4'h0;
    logic [3:0] ri = 4'h0;
    logic [3:0] ti = 4'h0;
    logic [3:0] si = 4'h0;
    int         idle = 0;
    int         cyc;
    for (int i = 0; i < 8; i++) wd[i] = 8'(xs());
    addr = 16'(xs());
    block_sel = 5'(xs());
    key = 8'(xs());
    dir = d;
    len_sel = m;
    var_len = {4'h0, n};
    tx_data = wd[0];
    go = 1'b1;
    @(posedge clk) #1;
    go = 1'b0;
    for (cyc = 0; cyc < 1200 && idle < 12; cyc++) begin
      @(posedge clk) #1;
      if (tx_next) begin
        ti++;
        tx_data = wd[ti[2:0]];
      end
      if (wr_stb) begin
        chk_word(wr_addr, addr + 16'(wi));
        chk_byte(wr_data, wd[wi[2:0]]);
        wi++;
      end
      if (rx_valid) begin
        chk_byte(rx_data, 8'(addr + 16'(ri)) ^ key);
        ri++;
      end
      if (rd_stb) begin
        chk_word(rd_addr, addr + 16'(si));
        si++;
      end
      idle = busy ? 0 : idle + 1;
    end
    if (cyc >= 1200) begin
      errors++;
      test_done();
    end
    chk_word({12'h0, d ? wi : ri}, {12'h0, nb});
    chk_word({12'h0, d ? ri : wi}, 16'h0000);
    chk_word({12'h0, ti}, {12'h0, d ? nb : 4'h0});
    $display("frame dir=%0d mode=%0d bytes=%0d done", d, m, nb);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    frame(1'b1, 2'h0, 4'h1);
    frame(1'b1, 2'h0, 4'h5);
    frame(1'b0, 2'h0, 4'h1);
    frame(1'b0, 2'h0, 4'h4);
    repeat (4) frame(1'(xs()), 2'h0, 4'h1 + 4'(xs() % 5));
    // Fixed frames last: the host never raises select again
    for (int k = 0; k < 6; k++) frame(k[0], 2'(k / 2 + 1), 4'h1);
    repeat (4) frame(1'(xs()), 2'h1 + 2'(xs() % 3), 4'h1);
    test_done();
  end
endmodule
